// ### src/energy_booster_config_regs.sv
// How it works
// - bit 4 of 0x0C picks storage ceiling, 0 = 9.9 V default, 1 = 11.0 V
// - bits 2:0 of 0x0A hold battery low threshold, default 000
// - bits 7:5 of 0x0A pick charge current, default 010; host avoids 101-111
// - bits 3:0 of 0x0B hold early-warning threshold, default 0000
// - bit 4 of 0x0B enables the early-warning comparison
// - bit 4 of 0x0A: 0 ties output to battery, 1 high impedance
// - profile index is 0x07 bits 1:0 above 0x08 bits 7:4
// - index zero means fixed mode, 1 to 63 means learning profile
// - bits 1:0 of 0x0D hold optimization headroom, default 11
// - gauge reads as 32 bits over 0x01..0x04, 0x01 most significant
// - gauge clears when the next charge cycle begins
// - live storage level updates only in charge or active state
// - charge target code loads on entry to charge state
// - 0x05 and 0x06 carry a 5-bit level code in bits 4:0
// - warning flag sets on low store while active, clears at charge start
// - bits 7:4 of 0x09 hold fixed end-of-charge level, default 0000
`timescale 1ns/100ps
`default_nettype none

module energy_booster_config_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // register port from the serial front end
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    // sequencer and measurement inputs
    input wire energy_booster_pkg::power_state_e power_state,
    input wire logic energy_valid,
    input wire logic [31:0] energy_value,
    input wire logic [4:0] store_code_in,
    input wire logic [4:0] target_code_in,
    input wire logic store_below_warn,
    // configuration outputs
    output logic store_ceiling_sel_q,
    output logic [2:0] battery_low_sel_q,
    output logic [2:0] charge_current_sel_q,
    output logic [3:0] warn_level_sel_q,
    output logic warn_enable_q,
    output logic pulse_output_rail_hiz_q,
    output logic [5:0] profile_index_q,
    output logic fixed_mode_q,
    output logic [1:0] headroom_sel_q,
    output logic [3:0] fixed_eoc_level_q,
    // status outputs
    output logic warning_flag_q,
    output logic [4:0] storage_level_now_q,
    output logic [4:0] charge_target_level_q
);
    import energy_booster_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // write strobe aimed at one offset
    function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] ofs);
        wr_hit = wr && (a == ofs);
    endfunction

    logic [5:0] profile_d;
    logic store_ceiling_sel_d, warn_enable_d, pulse_output_rail_hiz_d, fixed_mode_d;
    logic [2:0] battery_low_sel_d, charge_current_sel_d;
    logic [3:0] warn_level_sel_d, fixed_eoc_level_d;
    logic [1:0] headroom_sel_d;
    logic warning_flag_d;
    logic [4:0] storage_level_now_d, charge_target_level_d;
    logic [31:0] gauge_q, gauge_d, snap_q, snap_d;
    power_state_e prev_state_q;
    logic charge_start;
    logic [7:0] reg_rdata_d;
    logic reg_rvalid_d;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    // only the named field bits are copied; the rest of a written byte is dropped
    always_comb begin
        store_ceiling_sel_d = store_ceiling_sel_q;
        battery_low_sel_d = battery_low_sel_q;
        charge_current_sel_d = charge_current_sel_q;
        pulse_output_rail_hiz_d = pulse_output_rail_hiz_q;
        warn_level_sel_d = warn_level_sel_q;
        warn_enable_d = warn_enable_q;
        profile_d = profile_index_q;
        headroom_sel_d = headroom_sel_q;
        fixed_eoc_level_d = fixed_eoc_level_q;
        if (wr_hit(reg_wr, reg_addr, OFS_CEILING_CFG)) begin
            store_ceiling_sel_d = reg_wdata[CEILING_BIT];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_CHARGE_CFG)) begin
            battery_low_sel_d = reg_wdata[BATLOW_LSB +: 3];
            // codes 101..111 are stored as written; keeping clear of them is the host's job
            charge_current_sel_d = reg_wdata[CURRENT_LSB +: 3];
            pulse_output_rail_hiz_d = reg_wdata[HIZ_BIT];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_WARN_CFG)) begin
            warn_level_sel_d = reg_wdata[WARN_LVL_LSB +: 4];
            warn_enable_d = reg_wdata[WARN_EN_BIT];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_INDEX_UPPER)) begin
            profile_d[5:4] = reg_wdata[INDEX_UPPER_LSB +: 2];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_INDEX_LOWER)) begin
            profile_d[3:0] = reg_wdata[INDEX_LOWER_LSB +: 4];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_HEADROOM_CFG)) begin
            headroom_sel_d = reg_wdata[HEADROOM_LSB +: 2];
        end
        if (wr_hit(reg_wr, reg_addr, OFS_FIXED_EOC)) begin
            fixed_eoc_level_d = reg_wdata[FIXED_EOC_LSB +: 4];
        end
        // decoded from the next index so mode and index change together
        fixed_mode_d = (profile_d == 6'h00);
    end

    // register the configuration, defaults after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            store_ceiling_sel_q <= CEILING_RST;
            battery_low_sel_q <= BATLOW_RST;
            charge_current_sel_q <= CURRENT_RST;
            pulse_output_rail_hiz_q <= HIZ_RST;
            warn_level_sel_q <= WARN_LVL_RST;
            warn_enable_q <= WARN_EN_RST;
            profile_index_q <= PROFILE_RST;
            fixed_mode_q <= (PROFILE_RST == 6'h00);
            headroom_sel_q <= HEADROOM_RST;
            fixed_eoc_level_q <= FIXED_EOC_RST;
        end else begin
            store_ceiling_sel_q <= store_ceiling_sel_d;
            battery_low_sel_q <= battery_low_sel_d;
            charge_current_sel_q <= charge_current_sel_d;
            pulse_output_rail_hiz_q <= pulse_output_rail_hiz_d;
            warn_level_sel_q <= warn_level_sel_d;
            warn_enable_q <= warn_enable_d;
            profile_index_q <= profile_d;
            fixed_mode_q <= fixed_mode_d;
            headroom_sel_q <= headroom_sel_d;
            fixed_eoc_level_q <= fixed_eoc_level_d;
        end
    end

    // ------------------------------------------------------------
    // status tracking
    // ------------------------------------------------------------
    assign charge_start = (power_state == PS_CHARGE) && (prev_state_q != PS_CHARGE);

    // gauge, live level, target and warning flag
    always_comb begin
        gauge_d = gauge_q;
        if (charge_start) begin
            gauge_d = 32'h0000_0000;
        end else if (energy_valid) begin
            gauge_d = energy_value;
        end
        storage_level_now_d = storage_level_now_q;
        // standby leakage is deliberately not followed
        if (power_state == PS_CHARGE || power_state == PS_ACTIVE) begin
            storage_level_now_d = store_code_in;
        end
        charge_target_level_d = charge_target_level_q;
        if (charge_start) begin
            charge_target_level_d = target_code_in;
        end
        // set wins over the charge-start clear
        warning_flag_d = warning_flag_q;
        if (charge_start) begin
            warning_flag_d = 1'b0;
        end
        if (power_state == PS_ACTIVE && warn_enable_q && store_below_warn) begin
            warning_flag_d = 1'b1;
        end
    end

    // register status
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_state_q <= PS_STANDBY;
            gauge_q <= 32'h0000_0000;
            storage_level_now_q <= 5'h00;
            charge_target_level_q <= 5'h00;
            warning_flag_q <= 1'b0;
        end else begin
            prev_state_q <= power_state;
            gauge_q <= gauge_d;
            storage_level_now_q <= storage_level_now_d;
            charge_target_level_q <= charge_target_level_d;
            warning_flag_q <= warning_flag_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reading the top byte freezes the word so later bytes cannot tear
    always_comb begin
        snap_d = snap_q;
        reg_rdata_d = reg_rdata_q;
        reg_rvalid_d = reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                OFS_STATUS: begin
                    reg_rdata_d = 8'h00;
                    reg_rdata_d[STATUS_WARN_BIT] = warning_flag_q;
                end
                OFS_GAUGE3: begin
                    snap_d = gauge_q;
                    reg_rdata_d = gauge_q[31:24];
                end
                OFS_GAUGE2: reg_rdata_d = snap_q[23:16];
                OFS_GAUGE1: reg_rdata_d = snap_q[15:8];
                OFS_GAUGE0: reg_rdata_d = snap_q[7:0];
                OFS_STORE_NOW: reg_rdata_d = {3'h0, storage_level_now_q};
                OFS_TARGET: reg_rdata_d = {3'h0, charge_target_level_q};
                default: reg_rdata_d = 8'h00;
            endcase
        end
    end

    // register read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            snap_q <= 32'h0000_0000;
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            snap_q <= snap_d;
            reg_rdata_q <= reg_rdata_d;
            reg_rvalid_q <= reg_rvalid_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // field writes show on the outputs one cycle after the strobe
    ceiling_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_CEILING_CFG) |=>
        store_ceiling_sel_q == $past(reg_wdata[4]))
        else $error("ceiling select not stored");
    batlow_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_CHARGE_CFG) |=>
        battery_low_sel_q == $past(reg_wdata[2:0]) &&
        pulse_output_rail_hiz_q == $past(reg_wdata[4]))
        else $error("charge cfg low fields wrong");
    current_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_CHARGE_CFG) |=>
        charge_current_sel_q == $past(reg_wdata[7:5]))
        else $error("charge current not stored");
    warn_cfg_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_WARN_CFG) |=>
        warn_level_sel_q == $past(reg_wdata[3:0]) && warn_enable_q == $past(reg_wdata[4]))
        else $error("warning cfg wrong");
    index_lower_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_INDEX_LOWER) && !reg_rd |=>
        profile_index_q[3:0] == $past(reg_wdata[7:4]) && $stable(profile_index_q[5:4]))
        else $error("index lower nibble wrong");
    fixed_mode_a: assert property (
        fixed_mode_q == (profile_index_q == 6'h00))
        else $error("fixed mode mismatch");
    headroom_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_HEADROOM_CFG) |=>
        headroom_sel_q == $past(reg_wdata[1:0]))
        else $error("headroom not stored");
    // a four-byte burst must return the low byte of the word seen at the top-byte read
    gauge_coherent_a: assert property (
        (reg_rd && reg_addr == OFS_GAUGE3) ##1 (reg_rd && reg_addr == OFS_GAUGE2) ##1
        (reg_rd && reg_addr == OFS_GAUGE1) ##1 (reg_rd && reg_addr == OFS_GAUGE0) |=>
        reg_rdata_q == $past(gauge_q[7:0], 4))
        else $error("gauge bytes torn");
    gauge_clear_a: assert property (
        charge_start |=>
        gauge_q == 32'h0000_0000)
        else $error("gauge not cleared");
    store_hold_a: assert property (
        power_state == PS_STANDBY |=>
        $stable(storage_level_now_q))
        else $error("level moved in standby");
    store_track_a: assert property (
        power_state == PS_ACTIVE |=>
        storage_level_now_q == $past(store_code_in))
        else $error("level not tracked while active");
    target_load_a: assert property (
        charge_start |=>
        charge_target_level_q == $past(target_code_in))
        else $error("target not loaded");
    level_read_a: assert property (
        reg_rd && reg_addr == OFS_STORE_NOW |=>
        reg_rvalid_q && reg_rdata_q == {3'h0, $past(storage_level_now_q)})
        else $error("level read wrong");
    warn_set_a: assert property (
        $rose(warning_flag_q) |->
        $past(power_state) == PS_ACTIVE && $past(warn_enable_q))
        else $error("warning set outside active");
    warn_clear_a: assert property (
        charge_start |=>
        !warning_flag_q)
        else $error("warning not cleared at charge start");
    eoc_write_a: assert property (
        wr_hit(reg_wr, reg_addr, OFS_FIXED_EOC) |=>
        fixed_eoc_level_q == $past(reg_wdata[7:4]))
        else $error("fixed level not stored");

    // scenarios worth seeing in a run
    charge_entry_c: cover property (charge_start ##[1:20] power_state == PS_ACTIVE);
    warning_raise_c: cover property ($rose(warning_flag_q));
    gauge_read_c: cover property ((reg_rd && reg_addr == OFS_GAUGE3) ##[1:4]
        (reg_rd && reg_addr == OFS_GAUGE0));
    learning_mode_c: cover property ($fell(fixed_mode_q));
    emergency_current_c: cover property (charge_current_sel_q == 3'h4);

endmodule // energy_booster_config_regs

`default_nettype wire

// ### src/energy_booster_pkg.sv
`default_nettype none
package energy_booster_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_GAUGE3 = 4'h1;
    localparam logic [3:0] OFS_GAUGE2 = 4'h2;
    localparam logic [3:0] OFS_GAUGE1 = 4'h3;
    localparam logic [3:0] OFS_GAUGE0 = 4'h4;
    localparam logic [3:0] OFS_STORE_NOW = 4'h5;
    localparam logic [3:0] OFS_TARGET = 4'h6;
    localparam logic [3:0] OFS_INDEX_UPPER = 4'h7;
    localparam logic [3:0] OFS_INDEX_LOWER = 4'h8;
    localparam logic [3:0] OFS_FIXED_EOC = 4'h9;
    localparam logic [3:0] OFS_CHARGE_CFG = 4'hA;
    localparam logic [3:0] OFS_WARN_CFG = 4'hB;
    localparam logic [3:0] OFS_CEILING_CFG = 4'hC;
    localparam logic [3:0] OFS_HEADROOM_CFG = 4'hD;

    // ------------------------------------------------------------
    // field positions (lsb of each field) and the level code width
    // ------------------------------------------------------------
    localparam int BATLOW_LSB = 0;
    localparam int HIZ_BIT = 4;
    localparam int CURRENT_LSB = 5;
    localparam int WARN_LVL_LSB = 0;
    localparam int WARN_EN_BIT = 4;
    localparam int CEILING_BIT = 4;
    localparam int HEADROOM_LSB = 0;
    localparam int INDEX_UPPER_LSB = 0;
    localparam int INDEX_LOWER_LSB = 4;
    localparam int FIXED_EOC_LSB = 4;
    localparam int STATUS_WARN_BIT = 6;
    localparam int LEVEL_CODE_W = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] BATLOW_RST = 3'h0;
    localparam logic [2:0] CURRENT_RST = 3'h2;
    localparam logic HIZ_RST = 1'b0;
    localparam logic [3:0] WARN_LVL_RST = 4'h0;
    localparam logic WARN_EN_RST = 1'b0;
    localparam logic CEILING_RST = 1'b0;
    localparam logic [1:0] HEADROOM_RST = 2'h3;
    localparam logic [5:0] PROFILE_RST = 6'h00;
    localparam logic [3:0] FIXED_EOC_RST = 4'h0;

    // ------------------------------------------------------------
    // power states of the charge/active/standby sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_STANDBY = 2'b00,
        PS_CHARGE = 2'b01,
        PS_ACTIVE = 2'b10
    } power_state_e;

endpackage

`default_nettype wire

// ### test/energy_booster_config_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module energy_booster_config_regs_tb_top;
    import energy_booster_pkg::*;
    // ------------------------------------------------------------
    // signals, dut and host
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid_q, energy_valid, store_below_warn, warning_flag_q;
    logic [3:0] reg_addr, warn_level_sel_q, fixed_eoc_level_q, a;
    logic [7:0] reg_wdata, reg_rdata_q, d;
    logic [31:0] energy_value, g, snap;
    logic [35:0] burst;
    logic [4:0] store_code_in, target_code_in, storage_level_now_q, charge_target_level_q;
    logic [4:0] lvl, tgt;
    power_state_e power_state;
    logic store_ceiling_sel_q, warn_enable_q, pulse_output_rail_hiz_q, fixed_mode_q;
    logic [2:0] battery_low_sel_q, charge_current_sel_q;
    logic [5:0] profile_index_q;
    logic [1:0] headroom_sel_q;
    logic [7:0] m [16];
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;

    always #2 core_clk = ~core_clk;

    energy_booster_config_regs dut_u (
        .core_clk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
        .reg_rvalid_q, .power_state, .energy_valid, .energy_value, .store_code_in,
        .target_code_in, .store_below_warn, .store_ceiling_sel_q, .battery_low_sel_q,
        .charge_current_sel_q, .warn_level_sel_q, .warn_enable_q, .pulse_output_rail_hiz_q,
        .profile_index_q, .fixed_mode_q, .headroom_sel_q, .fixed_eoc_level_q,
        .warning_flag_q, .storage_level_now_q, .charge_target_level_q);
    host_model host_u (.core_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_q,
        .reg_rvalid_q);
    // ------------------------------------------------------------
    // compare and sequencing tasks
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chk_rd(input logic [3:0] ra, input logic [7:0] e);
        logic [8:0] got;
        host_u.rd(ra, got);
        cmp($sformatf("read %h", ra), 32'({1'b1, e}), 32'(got));
    endtask
    // config outputs against the shadow bytes of the model
    task automatic chk_cfg();
        cmp("config", 32'({m[12][4], m[10][2:0], m[10][7:5], m[11][3:0], m[11][4], m[10][4],
            m[7][1:0], m[8][7:4], ({m[7][1:0], m[8][7:4]} == 6'h00), m[13][1:0], m[9][7:4]}),
            32'({store_ceiling_sel_q, battery_low_sel_q, charge_current_sel_q, warn_level_sel_q,
            warn_enable_q, pulse_output_rail_hiz_q, profile_index_q, fixed_mode_q,
            headroom_sel_q, fixed_eoc_level_q}));
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // one gauge update pulse
    task automatic load(input logic [31:0] v);
        energy_valid = 1'b1;
        energy_value = v;
        step(1);
        energy_valid = 1'b0;
    endtask
    task automatic close_out();
        if (fails == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard, tests need well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(47145));
        power_state = PS_STANDBY;
        {energy_valid, store_below_warn, energy_value, store_code_in, target_code_in} = '0;
        foreach (m[i]) m[i] = 8'h00;
        m[10] = 8'h40;
        m[13] = 8'h03;
        step(5);
        reset_n = 1'b1;
        chk_cfg();
        // random writes, read-only and unmapped offsets must not land
        for (int i = 0; i < 40; i++) begin
            a = 4'($urandom_range(15, 0));
            host_u.wr(a, 8'($urandom), d);
            if (a >= 4'h7 && a <= 4'hD) m[a] = d;
            chk_cfg();
        end
        host_u.wr(4'h7, 8'hFC, m[7]);
        host_u.wr(4'h8, 8'h0F, m[8]);
        chk_cfg();
        for (int i = 7; i < 16; i++) chk_rd(4'(i), 8'h00);
        // gauge bytes, then a snapshot held across a new update
        power_state = PS_ACTIVE;
        g = $urandom;
        load(g);
        for (int i = 1; i < 5; i++) chk_rd(4'(i), 8'(g >> (32 - 8 * i)));
        snap = g;
        load($urandom);
        for (int i = 2; i < 5; i++) chk_rd(4'(i), 8'(snap >> (32 - 8 * i)));
        // burst read with a gauge update landing after the top byte
        g = $urandom;
        load(g);
        fork
            host_u.rd_gauge(burst);
            begin
                step(2);
                load($urandom);
            end
        join
        for (int i = 1; i < 5; i++) begin
            d = 8'(g >> (32 - 8 * i));
            cmp("gauge burst", 32'({1'b1, d}), 32'(burst[36 - 9 * i +: 9]));
        end
        // charge start with a colliding gauge update, clear must win
        power_state = PS_CHARGE;
        tgt = 5'($urandom);
        target_code_in = tgt;
        load($urandom);
        target_code_in = ~tgt;
        chk_rd(4'h1, 8'h00);
        chk_rd(4'h6, {3'h0, tgt});
        cmp("target out", {27'h0, tgt}, 32'(charge_target_level_q));
        // live level tracks in charge and active, frozen in standby
        lvl = 5'($urandom);
        store_code_in = lvl;
        step(2);
        chk_rd(4'h5, {3'h0, lvl});
        power_state = PS_STANDBY;
        step(1);
        store_code_in = ~lvl;
        step(3);
        chk_rd(4'h5, {3'h0, lvl});
        power_state = PS_ACTIVE;
        step(2);
        chk_rd(4'h5, {3'h0, ~lvl});
        cmp("level out", {27'h0, ~lvl}, 32'(storage_level_now_q));
        // warning sets when enabled and active, clears at charge start, stays clear when disabled
        host_u.wr(4'hB, 8'h10 | 8'($urandom_range(9, 0)), m[11]);
        store_below_warn = 1'b1;
        step(1);
        store_below_warn = 1'b0;
        chk_rd(4'h0, 8'h40);
        cmp("warning out", 32'h1, 32'(warning_flag_q));
        power_state = PS_STANDBY;
        step(1);
        power_state = PS_CHARGE;
        step(1);
        chk_rd(4'h0, 8'h00);
        host_u.wr(4'hB, 8'h05, m[11]);
        power_state = PS_ACTIVE;
        store_below_warn = 1'b1;
        step(3);
        store_below_warn = 1'b0;
        chk_rd(4'h0, 8'h00);
        chk_cfg();
        close_out();
    end
endmodule // energy_booster_config_regs_tb_top
`default_nettype wire

// ### test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// host side of the register port
// ------------------------------------------------------------
module host_model (
    // clock
    input wire logic core_clk,
    // register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic reg_rvalid_q
);
    // idle port from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end
    // one write, the byte really sent is handed back
    task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [7:0] sent);
        @(posedge core_clk);
        #1;
        sent = d;
        // undefined current codes are never issued by the host
        if (a == 4'hA && d[7:5] > 3'h4) sent[7:5] = 3'h4;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = sent;
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        // released lines carry junk so a stale value cannot pass
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    // one read, answer sampled just after the following edge
    task automatic rd(input logic [3:0] a, output logic [8:0] got);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        got = {reg_rvalid_q, reg_rdata_q};
    endtask
    // gauge bytes 0x01..0x04 back to back, strobe held high across the burst
    task automatic rd_gauge(output logic [35:0] got);
        @(posedge core_clk);
        #1;
        reg_rd = 1'b1;
        for (int i = 1; i < 5; i++) begin
            reg_addr = 4'(i);
            @(posedge core_clk);
            #1;
            got[36 - 9 * i +: 9] = {reg_rvalid_q, reg_rdata_q};
        end
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
    endtask
endmodule // host_model
`default_nettype wire
